// [rtl/rcc_pkg.sv]
// Constants, register layout and timing for the reset cause capture block.
// Assumes an Avalon-MM slave with 32-bit data on a 50 MHz clock.
package rcc_pkg;
  // Register map (byte addresses)
  localparam logic [3:0]  RCC_OFS_STATUS = 4'h0;
  localparam logic [3:0]  RCC_OFS_SHADOW = 4'h4;
  localparam logic [3:0]  RCC_OFS_CTRL   = 4'h8;
  // Status bit positions
  localparam int RCC_B_TRAP = 15;
  localparam int RCC_B_ILL  = 14;
  localparam int RCC_B_CFG  = 9;
  localparam int RCC_B_EXT  = 7;
  localparam int RCC_B_SOFT = 6;
  localparam int RCC_B_WDOG = 4;
  localparam int RCC_B_SLP  = 3;
  localparam int RCC_B_IDL  = 2;
  localparam int RCC_B_BROWN = 1;
  localparam int RCC_B_POR  = 0;
  localparam logic [15:0] RCC_STATUS_MASK = 16'hC2DF;
  localparam logic [15:0] RCC_STATUS_RST  = 16'h0003;
  // Trap levels and opcode
  localparam logic [3:0]  RCC_HARD_LO  = 4'hD;
  localparam logic [3:0]  RCC_HARD_HI  = 4'hF;
  localparam logic [7:0]  RCC_ILL_OP   = 8'h3F;
  localparam logic [23:0] RCC_PC_RESET = 24'h000000;
  // Working registers: all are tracked; only the stack pointer is exempt from the check
  localparam int RCC_NUM_W = 16;
  localparam int RCC_SP_IDX = 15;
  // Reset pulse: one instruction cycle
  localparam int RCC_TCY_NS = 40;
  localparam int RCC_CLK_NS = 20;
  localparam int RCC_PULSE_CYC = (RCC_TCY_NS + RCC_CLK_NS - 1) / RCC_CLK_NS;
  typedef enum logic [1:0] {RCC_IDLE, RCC_HOLD} rcc_state_t;
endpackage

// [rtl/rcc_reset_cause.sv]
// Reset cause capture: merges reset sources, keeps the cause register.
// Assumes event inputs come from same-clock core logic, pins are async.
`timescale 1ns/100ps
module rcc_reset_cause
  import rcc_pkg::*;
#(
  parameter int PPS_W = 32
)(
  // Clock and reset
  input  wire logic              clk,
  input  wire logic              rstn,
  // Power and pin reset sources (async)
  input  wire logic              por_evt,
  input  wire logic              brownout_evt,
  input  wire logic              master_clear_pin_n,
  // Watchdog and power state
  input  wire logic              watchdog_timeout,
  input  wire logic              cpu_sleep,
  input  wire logic              cpu_idle,
  input  wire logic              power_save_sleep,
  input  wire logic              power_save_idle,
  input  wire logic              watchdog_clear_instruction,
  // Core events
  input  wire logic              soft_reset_instruction,
  input  wire logic              trap_req,
  input  wire logic [3:0]        trap_level,
  input  wire logic              trap_active,
  input  wire logic [3:0]        trap_active_level,
  input  wire logic              exec_valid,
  input  wire logic [7:0]        exec_opcode_hi,
  input  wire logic              w_write,
  input  wire logic [3:0]        w_write_idx,
  input  wire logic              w_ptr_use,
  input  wire logic [3:0]        w_ptr_idx,
  input  wire logic              program_flow_change,
  input  wire logic              vector_flow_change,
  input  wire logic              target_restricted,
  input  wire logic [PPS_W-1:0]  pps_regs,
  // Avalon-MM slave
  input  wire logic [3:0]        avs_address,
  input  wire logic              avs_read,
  input  wire logic              avs_write,
  input  wire logic [31:0]       avs_writedata,
  input  wire logic [3:0]        avs_byteenable,
  output logic [31:0]            avs_readdata,
  output logic                   avs_waitrequest,
  // Reset outputs
  output logic                   system_reset_line,
  output logic                   cpu_wake,
  output logic [23:0]            pc_load,
  output logic                   pc_force,
  output logic [RCC_NUM_W-1:0]   w_init
);

  // Pulse counter is two bits wide, so the pulse must fit in four cycles
  if (PPS_W < 1 || RCC_PULSE_CYC < 1 || RCC_PULSE_CYC > 4)
  begin : g_bad_cfg
    $error("unsupported pin-select width or reset pulse length");
  end

  ////////////////////////////////////////////////////////////////////////////
  // Pin synchronisers
  logic [1:0] por_s_r;
  logic [1:0] brown_s_r;
  logic [1:0] pin_s_r;
  always_ff @(posedge clk or negedge rstn)
    if (!rstn)
    begin
      por_s_r   <= 2'h0;
      brown_s_r <= 2'h0;
      pin_s_r   <= 2'h3;
    end
    else
    begin
      por_s_r   <= {por_s_r[0], por_evt};
      brown_s_r <= {brown_s_r[0], brownout_evt};
      pin_s_r   <= {pin_s_r[0], master_clear_pin_n};
    end

  wire por_q     = por_s_r[1];
  wire brown_q   = brown_s_r[1];
  wire pin_rst_q = ~pin_s_r[1];

  ////////////////////////////////////////////////////////////////////////////
  // Reset source decode
  wire in_low_power = cpu_sleep | cpu_idle;
  wire wdog_rst  = watchdog_timeout & ~in_low_power;
  wire wdog_wake = watchdog_timeout & in_low_power;
  wire new_hard = (trap_level >= RCC_HARD_LO)
                & (trap_level <= RCC_HARD_HI);
  wire act_hard = (trap_active_level >= RCC_HARD_LO)
                & (trap_active_level <= RCC_HARD_HI);
  wire trap_rst = trap_req & trap_active & new_hard & act_hard
                & (trap_level < trap_active_level);
  wire ill_op   = exec_valid & (exec_opcode_hi == RCC_ILL_OP);
  logic [RCC_NUM_W-1:0] w_init_r;
  wire uninit   = w_ptr_use & (w_ptr_idx != RCC_SP_IDX[3:0])
                & ~w_init_r[w_ptr_idx];
  wire flow_chg = program_flow_change | vector_flow_change;
  wire sec_rst  = flow_chg & target_restricted;
  wire ill_rst  = ill_op | uninit | sec_rst;

  logic [PPS_W-1:0] shadow_r;
  logic             shadow_armed_r;
  // A reload write masks the compare so a legitimate update cannot trip it
  wire pps_load = avs_write & (avs_address == RCC_OFS_CTRL)
                & avs_byteenable[0] & avs_writedata[0];
  wire cfg_rst  = shadow_armed_r & ~pps_load
                & (pps_regs != shadow_r);

  wire pwr_rst  = por_q | brown_q;
  wire core_rst = trap_rst | ill_rst | cfg_rst | pin_rst_q;

  ////////////////////////////////////////////////////////////////////////////
  // Reset request: one line for all sources
  rcc_state_t state_r;
  logic [1:0] pulse_cnt_r;
  always_ff @(posedge clk or negedge rstn)
    if (!rstn)
    begin
      state_r     <= RCC_IDLE;
      pulse_cnt_r <= 2'h0;
    end
    else
    begin
      case (state_r)
        RCC_IDLE:
          if (soft_reset_instruction | core_rst | pwr_rst)
          begin
            state_r     <= RCC_HOLD;
            pulse_cnt_r <= RCC_PULSE_CYC[1:0] - 2'h1;
          end
        RCC_HOLD:
          if (pulse_cnt_r != 2'h0)
            pulse_cnt_r <= pulse_cnt_r - 2'h1;
          else if (!(core_rst | pwr_rst))
            state_r <= RCC_IDLE;
        default:
          state_r <= RCC_IDLE;
      endcase
    end

  // Watchdog path bypasses the flops so reset asserts without a clock edge
  assign system_reset_line = (state_r == RCC_HOLD) | wdog_rst;
  assign cpu_wake          = wdog_wake;
  assign pc_force          = system_reset_line;
  assign pc_load           = RCC_PC_RESET;

  ////////////////////////////////////////////////////////////////////////////
  // Working register init tracking and pin-select shadow
  always_ff @(posedge clk or negedge rstn)
    if (!rstn)
    begin
      w_init_r       <= '0;
      shadow_r       <= '0;
      shadow_armed_r <= 1'b0;
    end
    else if (system_reset_line)
    begin
      w_init_r       <= '0;
      shadow_armed_r <= 1'b0;
    end
    else
    begin
      if (w_write)
        w_init_r[w_write_idx] <= 1'b1;
      // Shadow follows legitimate writes via the reload strobe
      if (!shadow_armed_r | pps_load)
        shadow_r <= pps_regs;
      shadow_armed_r <= 1'b1;
    end
  assign w_init = w_init_r;

  ////////////////////////////////////////////////////////////////////////////
  // Register bus: zero wait for writes, one wait cycle for reads
  logic        rd_done_r;
  logic [31:0] rdata_r;
  logic [15:0] status_r;
  wire sel_status = avs_address == RCC_OFS_STATUS;
  wire sel_shadow = avs_address == RCC_OFS_SHADOW;
  wire wr_status  = avs_write & sel_status;
  wire [15:0] be_mask = {{8{avs_byteenable[1]}}, {8{avs_byteenable[0]}}};
  wire [31:0] rd_mux  = sel_status ? {16'h0000, status_r}
                      : sel_shadow ? 32'(shadow_r)
                      : 32'h00000000;
  assign avs_waitrequest = avs_read & ~rd_done_r;
  assign avs_readdata    = rdata_r;

  always_ff @(posedge clk or negedge rstn)
    if (!rstn)
    begin
      rd_done_r <= 1'b0;
      rdata_r   <= 32'h00000000;
    end
    else
    begin
      rd_done_r <= avs_read & ~rd_done_r;
      if (avs_read & ~rd_done_r)
        rdata_r <= rd_mux;
    end

  ////////////////////////////////////////////////////////////////////////////
  // Cause register: software write first, hardware set wins over it
  logic [15:0] set_v;
  logic [15:0] clr_v;
  logic [15:0] status_nxt;
  always_comb
  begin
    set_v = 16'h0000;
    clr_v = 16'h0000;
    set_v[RCC_B_TRAP] = trap_rst;
    set_v[RCC_B_ILL]  = ill_rst;
    set_v[RCC_B_CFG]  = cfg_rst;
    set_v[RCC_B_EXT]  = pin_rst_q;
    set_v[RCC_B_SOFT] = soft_reset_instruction;
    set_v[RCC_B_WDOG] = wdog_rst;
    set_v[RCC_B_SLP]  = power_save_sleep;
    set_v[RCC_B_IDL]  = power_save_idle;
    set_v[RCC_B_BROWN] = pwr_rst;
    set_v[RCC_B_POR]  = por_q;
    if (pwr_rst)
      clr_v = RCC_STATUS_MASK & ~16'h0083;
    if (por_q)
      clr_v[RCC_B_EXT] = 1'b1;
    if (power_save_sleep | power_save_idle | watchdog_clear_instruction)
      clr_v[RCC_B_WDOG] = 1'b1;
    status_nxt = status_r;
    if (wr_status)
      status_nxt = (status_r & ~be_mask)
                 | (avs_writedata[15:0] & be_mask);
    status_nxt = ((status_nxt & ~clr_v) | set_v) & RCC_STATUS_MASK;
  end

  // Async reset models power-on: cause shows power-on and brown-out
  always_ff @(posedge clk or negedge rstn)
    if (!rstn)
      status_r <= RCC_STATUS_RST;
    else
      status_r <= status_nxt;

endmodule

// [verif/rcc_reset_cause_monitor.sv]
// Checker: reset merge, cause triggers and bus wait timing.
// Assumes a bind onto rcc_reset_cause; rstn is the only reset.
`timescale 1ns/100ps
module rcc_reset_cause_monitor
  import rcc_pkg::*;
(
  // Core and watchdog inputs
  input wire logic                 clk, rstn, watchdog_timeout, cpu_sleep,
  input wire logic                 cpu_idle, soft_reset_instruction,
  input wire logic                 trap_req, trap_active, exec_valid,
  input wire logic [3:0]           trap_level, trap_active_level, w_ptr_idx,
  input wire logic                 w_ptr_use, program_flow_change,
  input wire logic                 vector_flow_change, target_restricted,
  input wire logic [7:0]           exec_opcode_hi,
  // Bus and reset outputs
  input wire logic                 avs_read, avs_write, avs_waitrequest,
  input wire logic                 system_reset_line, cpu_wake, pc_force,
  input wire logic [23:0]          pc_load,
  input wire logic [RCC_NUM_W-1:0] w_init
);
  default clocking @(posedge clk); endclocking
  default disable iff (!rstn);
  wire run  = !cpu_sleep && !cpu_idle;
  wire hard = trap_level >= RCC_HARD_LO && trap_active_level >= RCC_HARD_LO;
  wire bad_w = w_ptr_use && w_ptr_idx != 4'hF && !w_init[w_ptr_idx];
  wire flow = program_flow_change || vector_flow_change;
  ////////////////////////////////////////////////////////////////////////////
  timeout_run_a:
    assert property (watchdog_timeout && run |-> system_reset_line)
    else $error("run mode timeout gave no reset");
  timeout_sleep_a:
    assert property (watchdog_timeout && !run
      |-> cpu_wake && !system_reset_line)
    else $error("sleep timeout did not just wake");
  trap_conf_a:
    assert property (trap_req && trap_active && hard &&
      trap_level < trap_active_level |-> ##[0:3] system_reset_line)
    else $error("trap conflict gave no reset");
  bad_opcode_a:
    assert property (exec_valid && exec_opcode_hi == RCC_ILL_OP
      |-> ##[0:3] system_reset_line)
    else $error("illegal opcode gave no reset");
  uninit_ptr_a:
    assert property (bad_w |-> ##[0:3] system_reset_line)
    else $error("uninitialized pointer gave no reset");
  secure_flow_a:
    assert property (flow && target_restricted |-> ##[0:3] system_reset_line)
    else $error("restricted flow change gave no reset");
  soft_pulse_a:
    assert property (soft_reset_instruction |=> system_reset_line [*2])
    else $error("soft reset pulse too short");
  pc_zero_a:
    assert property (system_reset_line |-> pc_force && pc_load == RCC_PC_RESET)
    else $error("reset did not force pc to zero");
  read_wait_a:
    assert property (avs_read && avs_waitrequest |=> !avs_waitrequest)
    else $error("read wait longer than one cycle");
endmodule

// [verif/rcc_core_model.sv]
// Partner model: core, decoder and trap unit raising fault events.
// Assumes one go pulse per command; a fault repeats until reset lands.
`timescale 1ns/100ps
module rcc_core_model
  import rcc_pkg::*;
(
  // Clock, reset, command
  input  wire logic       clk, rstn, go, system_reset_line,
  input  wire logic [2:0] op,
  // Core events
  output logic            soft_reset_instruction, trap_req, trap_active,
  output logic [3:0]      trap_level, trap_active_level, w_write_idx,
  output logic [3:0]      w_ptr_idx,
  output logic            exec_valid, w_write, w_ptr_use,
  output logic [7:0]      exec_opcode_hi,
  output logic            program_flow_change, vector_flow_change,
  output logic            target_restricted
);
  logic [2:0] op_r;
  logic       on_r;
  wire  [7:0] hot  = on_r ? 8'h01 << op_r : 8'h00;
  wire        held = op_r inside {[3'h1:3'h5]};
  ////////////////////////////////////////////////////////////////////////////
  always_ff @(posedge clk)
    if (go)
      op_r <= op;
  // A stuck core retries its fault, so only reset ends it
  always_ff @(posedge clk or negedge rstn)
    if (!rstn)
      on_r <= 1'b0;
    else
      on_r <= go || (on_r && held && !system_reset_line);
  assign {w_write, w_ptr_use, exec_valid, soft_reset_instruction} =
    {hot[6], hot[2], hot[1], hot[0]};
  assign {vector_flow_change, program_flow_change} = hot[4:3];
  assign target_restricted = |hot[4:3];
  assign exec_opcode_hi = exec_valid ? RCC_ILL_OP : ~RCC_ILL_OP;
  assign trap_req = hot[5] || hot[7];
  assign trap_active = trap_req;
  assign trap_level = hot[5] ? RCC_HARD_LO : 4'hC;
  assign trap_active_level = RCC_HARD_HI;
  assign w_ptr_idx = 4'h5;
  assign w_write_idx = 4'h3;
endmodule

// [verif/rcc_reset_cause_test.sv]
// Bench for rcc_reset_cause: bus tasks, core model, reset causes.
// Assumes rcc_pkg, the core model and the monitor compile first.
`timescale 1ns/100ps
module rcc_reset_cause_test
  import rcc_pkg::*;
;
  logic clk, rstn, go, por_evt, brownout_evt, power_save_idle, cpu_wake;
  logic watchdog_timeout, cpu_sleep, cpu_idle, power_save_sleep;
  logic watchdog_clear_instruction, master_clear_pin_n, avs_read;
  logic avs_write, avs_waitrequest, system_reset_line, exec_valid;
  logic soft_reset_instruction, trap_req, trap_active, w_write, w_ptr_use;
  logic program_flow_change, vector_flow_change, target_restricted;
  logic [2:0] op;
  logic [3:0] avs_address, avs_byteenable, trap_level, trap_active_level;
  logic [3:0] w_write_idx, w_ptr_idx;
  logic [7:0] exec_opcode_hi;
  logic [31:0] pps_regs, avs_writedata, avs_readdata;
  logic [15:0] exp_q[$], r;
  logic [15:0] exp_tab[8] = '{16'h0040, 16'h4000, 16'h4000, 16'h4000,
    16'h4000, 16'h8000, 16'h0000, 16'h0000};
  int bad_count, cmp_count, cyc, i;
  rcc_reset_cause #(.PPS_W(32)) u_dut
    (.*, .pc_load(), .pc_force(), .w_init());
  rcc_core_model u_core (.*);
  ////////////////////////////////////////////////////////////////////////////
  task automatic report_and_stop;
    $display("compares %0d mismatches %0d", cmp_count, bad_count);
    if (bad_count == 0 && cmp_count > 0)
      $display("bench passed");
    else
      $display("bench failed");
    $finish;
  endtask
  task automatic bus(input logic wr, input logic [3:0] a,
                     input logic [15:0] d);
    avs_write <= wr;
    avs_read <= !wr;
    avs_address <= a;
    avs_writedata <= {16'h0000, d};
    @(posedge clk iff avs_waitrequest === 1'b0);
    {avs_write, avs_read} <= 2'b00;
    @(posedge clk);
  endtask
  task automatic rd(input logic [3:0] a, input logic [15:0] e);
    exp_q.push_back(e);
    bus(1'b0, a, 16'h0000);
  endtask
  // Sources settle within four cycles; then wait out the reset
  task automatic settle;
    repeat (4) @(posedge clk);
    @(posedge clk iff system_reset_line === 1'b0);
  endtask
  ////////////////////////////////////////////////////////////////////////////
  initial
  begin
    clk = 1'b0;
    forever #10 clk = ~clk;
  end
  always @(posedge clk)
  begin
    cyc <= cyc + 1;
    if (avs_read === 1'b1 && avs_waitrequest === 1'b0)
    begin
      r = exp_q.pop_front();
      cmp_count++;
      if (avs_readdata[15:0] !== r)
      begin
        bad_count++;
        $display("Error %0t got %h exp %h", $time, avs_readdata[15:0], r);
      end
    end
    // Ceiling well above the few hundred cycles the tests need
    if (cyc == 5000)
    begin
      bad_count++;
      report_and_stop();
    end
  end
  initial
  begin
    {go, op, por_evt, brownout_evt, power_save_idle, watchdog_timeout} = '0;
    {cpu_sleep, cpu_idle, power_save_sleep, avs_read, avs_write} = '0;
    {watchdog_clear_instruction, rstn, avs_address, pps_regs} = '0;
    {master_clear_pin_n, avs_byteenable, avs_writedata} = {5'h1F, 32'h0};
    void'($urandom(50));
    repeat (2) @(posedge clk);
    rstn <= 1'b1;
    @(posedge clk);
    rd(4'h0, RCC_STATUS_RST);
    rd(4'hC, 16'h0000);
    for (i = 0; i < 4; i++)
    begin
      bus(1'b1, 4'h0, 16'($urandom));
      rd(4'h0, avs_writedata[15:0] & RCC_STATUS_MASK);
    end
    bus(1'b1, 4'h0, 16'h0000);
    $display("test register access done");
    for (i = 0; i < 8; i++)
    begin
      {op, go} <= {i[2:0], 1'b1};
      @(posedge clk);
      go <= 1'b0;
      settle();
      rd(4'h0, exp_tab[i]);
      bus(1'b1, 4'h0, 16'h0000);
    end
    $display("test core causes done");
    for (i = 0; i < 4; i++)
    begin
      {cpu_sleep, cpu_idle, watchdog_timeout} <= {i == 2, i == 3, 1'b1};
      @(posedge clk);
      watchdog_timeout <= 1'b0;
      settle();
      rd(4'h0, i < 2 ? 16'h0010 : 16'h0000);
      {power_save_sleep, watchdog_clear_instruction} <= {i == 0, i == 1};
      @(posedge clk);
      {power_save_sleep, watchdog_clear_instruction} <= 2'b00;
      @(posedge clk);
      rd(4'h0, i == 0 ? 16'h0008 : 16'h0000);
      bus(1'b1, 4'h0, 16'h0000);
    end
    {cpu_sleep, cpu_idle} <= 2'b00;
    $display("test watchdog done");
    pps_regs <= $urandom | 32'h1;
    settle();
    rd(4'h0, 16'h0200);
    rd(4'h4, pps_regs[15:0]);
    bus(1'b1, 4'h0, 16'h0000);
    // Reload strobe and new pin-select value arrive in the same cycle
    pps_regs <= $urandom | 32'h2;
    bus(1'b1, 4'h8, 16'h0001);
    rd(4'h0, 16'h0000);
    rd(4'h4, pps_regs[15:0]);
    master_clear_pin_n <= 1'b0;
    repeat (4) @(posedge clk);
    master_clear_pin_n <= 1'b1;
    settle();
    rd(4'h0, 16'h0080);
    for (i = 0; i < 2; i++)
    begin
      bus(1'b1, 4'h0, 16'hC2DC);
      {por_evt, brownout_evt} <= {i == 1, i == 0};
      repeat (4) @(posedge clk);
      {por_evt, brownout_evt} <= 2'b00;
      settle();
      rd(4'h0, i == 1 ? 16'h0003 : 16'h0082);
    end
    $display("test pins done");
    report_and_stop();
  end
endmodule
bind rcc_reset_cause rcc_reset_cause_monitor u_mon (.*);
